// ==== verilog/dcs_map.vh ====
`ifndef DCS_MAP_VH
`define DCS_MAP_VH
// ------------------------------------------------------------
// character codes (6-bit): 0x00..0x0F hex digits, then letters
// ------------------------------------------------------------
`define DCS_CH_W        6
`define DCS_CH_0        6'h00
`define DCS_CH_8        6'h08
`define DCS_CH_A        6'h0A
`define DCS_CH_B        6'h0B
`define DCS_CH_C        6'h0C
`define DCS_CH_D        6'h0D
`define DCS_CH_E        6'h0E
`define DCS_CH_F        6'h0F
`define DCS_CH_H        6'h10
`define DCS_CH_L        6'h11
`define DCS_CH_N        6'h12
`define DCS_CH_O        6'h13
`define DCS_CH_P        6'h14
`define DCS_CH_R        6'h15
`define DCS_CH_S        6'h16
`define DCS_CH_U        6'h17
`define DCS_CH_Y        6'h18
`define DCS_CH_DASH     6'h3E
`define DCS_CH_BLANK    6'h3F
// ------------------------------------------------------------
// segment bit positions, segs[6:0] = g f e d c b a
// ------------------------------------------------------------
`define DCS_SEG_W       7
`define DCS_SEG_OFF     7'h00
`define DCS_SEG_MID     7'h40
// ------------------------------------------------------------
// display modes, in priority order low to high
// ------------------------------------------------------------
`define DCS_MODE_W      3
`define DCS_MODE_ID     3'h0
`define DCS_MODE_SOD    3'h1
`define DCS_MODE_BATT   3'h2
`define DCS_MODE_HOT    3'h3
`define DCS_MODE_OFFL   3'h4
`define DCS_MODE_POWER  3'h5
`define DCS_MODE_DIAG   3'h6
// ------------------------------------------------------------
// component failure kinds (detail code first character)
// ------------------------------------------------------------
`define DCS_CF_W        3
`define DCS_CF_COMB     3'h0
`define DCS_CF_CACHE    3'h1
`define DCS_CF_PROC     3'h2
`define DCS_CF_HOST     3'h3
`define DCS_CF_FLASH    3'h4
`define DCS_CF_BASE     3'h5
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DCS_CLK_HZ      100000000
`define DCS_DWELL_MS    500
`define DCS_DWELL_CYC   ((`DCS_CLK_HZ / 1000) * `DCS_DWELL_MS)
`define DCS_MAX_CODES   8
`endif

// ==== verilog/dcs_glyph.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.vh"
module dcs_glyph (
  input  wire [`DCS_CH_W-1:0]  ch,
  output reg  [`DCS_SEG_W-1:0] segs
);
  // ------------------------------------------------------------
  // glyph lookup
  // ------------------------------------------------------------
  always @* begin
    case (ch)
      6'h00:         segs = 7'h3F;
      6'h01:         segs = 7'h06;
      6'h02:         segs = 7'h5B;
      6'h03:         segs = 7'h4F;
      6'h04:         segs = 7'h66;
      6'h05:         segs = 7'h6D;
      6'h06:         segs = 7'h7D;
      6'h07:         segs = 7'h07;
      6'h08:         segs = 7'h7F;
      6'h09:         segs = 7'h6F;
      `DCS_CH_A:     segs = 7'h77;
      `DCS_CH_B:     segs = 7'h7C;
      `DCS_CH_C:     segs = 7'h39;
      `DCS_CH_D:     segs = 7'h5E;
      `DCS_CH_E:     segs = 7'h79;
      `DCS_CH_F:     segs = 7'h71;
      `DCS_CH_H:     segs = 7'h76;
      `DCS_CH_L:     segs = 7'h38;
      `DCS_CH_N:     segs = 7'h54;
      `DCS_CH_O:     segs = 7'h3F;
      `DCS_CH_P:     segs = 7'h73;
      `DCS_CH_R:     segs = 7'h50;
      // letter s reuses the five glyph
      `DCS_CH_S:     segs = 7'h6D; // [R22]
      `DCS_CH_U:     segs = 7'h3E;
      `DCS_CH_Y:     segs = 7'h6E;
      `DCS_CH_DASH:  segs = `DCS_SEG_MID; // [R3]
      default:       segs = `DCS_SEG_OFF; // [R4]
    endcase
  end
endmodule // dcs_glyph
`default_nettype wire

// ==== verilog/dcs_sequencer.v ====
// Behaviour
// [R1] boot errors with attention on show a sequence of two-character codes
// [R2] plus codes light the diagnostic dot, minus codes keep it dark
// [R3] separator lights only middle segments with the dot on
// [R4] end glyph blanks all segments and the dot
// [R5] separator only between pairs when more than one pair exists
// [R6] end glyph appended automatically, then the sequence repeats
// [R7] startup error followed by default, diagnostic fault or validation code
// [R8] operational error followed by lockdown code with its index
// [R9] diagnostic failure followed by a lockdown code
// [R10] component failure detail codes carry the part location
// [R11] combined memory code for shared memory, separate codes otherwise
// [R12] normal operation shows static enclosure id with dot off
// [R13] reset while showing id shows offline sequence, controller held
// [R14] component failure while online shown, persists after going offline
// [R15] power-on default sequence during power-on or held insertion
// [R16] start-of-day running shows start-of-day sequence
// [R17] battery backup shows battery sequence
// [R18] over temperature shows over-temperature sequence
// [R19] non-replaceable diagnostic failure shows diagnostic fault sequence
// [R20] host card failure shows component failure with host code
// [R21] each character dwells a parameter time before advancing
// [R22] fixed glyph table, letter s drawn as five
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.vh"
module dcs_sequencer #(
  parameter DWELL_CYC = `DCS_DWELL_CYC
) (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  attention_indicator,
  input  wire                  power_on_phase,
  input  wire                  start_of_day,
  input  wire                  battery_backup,
  input  wire                  over_temp,
  input  wire                  ctrl_reset_req,
  input  wire                  diag_fault,
  input  wire                  validation_err,
  input  wire [3:0]            validation_idx,
  input  wire                  op_lockdown,
  input  wire                  diag_lockdown,
  input  wire [`DCS_CH_W-1:0]  lockdown_ch,
  input  wire                  comp_fail,
  input  wire [`DCS_CF_W-1:0]  comp_kind,
  input  wire [3:0]            comp_loc,
  input  wire                  comp_clear,
  input  wire [`DCS_CH_W-1:0]  encl_id_hi,
  input  wire [`DCS_CH_W-1:0]  encl_id_lo,
  output reg  [`DCS_SEG_W-1:0] seg_hi_ff,
  output reg  [`DCS_SEG_W-1:0] seg_lo_ff,
  output reg                   diag_dot_ff,
  output reg                   ctrl_hold_ff
);
  // ------------------------------------------------------------
  // sticky state
  // ------------------------------------------------------------
  reg                   showing_id_ff;
  reg                   offline_ff;
  reg                   cf_seen_ff;
  reg [`DCS_CF_W-1:0]   cf_kind_ff;
  reg [3:0]             cf_loc_ff;
  reg [2:0]             idx_ff;
  reg [31:0]            dwell_ff;
  reg                   nxt_offline;
  reg                   nxt_cf_seen;

  always @* begin
    nxt_offline = offline_ff;
    if (ctrl_reset_req && showing_id_ff)
      nxt_offline = 1'b1; // [R13]
    else if (!ctrl_reset_req)
      nxt_offline = 1'b0;
    // a failure arriving with a clear wins, so none is lost
    nxt_cf_seen = cf_seen_ff;
    if (comp_clear)
      nxt_cf_seen = 1'b0;
    if (comp_fail)
      nxt_cf_seen = 1'b1; // [R14]
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      offline_ff   <= 1'b0;
      cf_seen_ff   <= 1'b0;
      cf_kind_ff   <= `DCS_CF_COMB;
      cf_loc_ff    <= 4'h0;
      ctrl_hold_ff <= 1'b0;
    end else begin
      offline_ff   <= nxt_offline;
      cf_seen_ff   <= nxt_cf_seen;
      ctrl_hold_ff <= nxt_offline; // [R13]
      if (comp_fail) begin
        cf_kind_ff <= comp_kind;
        cf_loc_ff  <= comp_loc;
      end
    end
  end

  // ------------------------------------------------------------
  // sequence builder: up to five codes, end glyph appended
  // ------------------------------------------------------------
  reg [`DCS_CH_W-1:0] c_hi [0:`DCS_MAX_CODES-1];
  reg [`DCS_CH_W-1:0] c_lo [0:`DCS_MAX_CODES-1];
  reg [3:0]           n_codes;
  reg                 static_id;
  reg [`DCS_CH_W-1:0] det_hi;
  reg [`DCS_CH_W-1:0] det_lo;
  reg                 err_pair;
  reg [3:0]           k;
  // validation index in the low nibble maps to hex digit codes
  wire [`DCS_CH_W-1:0] val_ch = {2'b00, validation_idx};
  wire [`DCS_CH_W-1:0] loc_ch = {2'b00, cf_loc_ff};

  always @* begin
    for (k = 4'd0; k < `DCS_MAX_CODES; k = k + 4'd1) begin
      c_hi[k[2:0]] = `DCS_CH_BLANK;
      c_lo[k[2:0]] = `DCS_CH_BLANK;
    end
    n_codes   = 4'd0;
    static_id = 1'b0;
    err_pair  = 1'b0;
    case (cf_kind_ff)
      `DCS_CF_COMB:  det_hi = `DCS_CH_D; // [R11]
      `DCS_CF_CACHE: det_hi = `DCS_CH_C; // [R11]
      `DCS_CF_PROC:  det_hi = `DCS_CH_P;
      `DCS_CF_HOST:  det_hi = `DCS_CH_H; // [R20]
      `DCS_CF_FLASH: det_hi = `DCS_CH_F;
      default:       det_hi = `DCS_CH_B;
    endcase
    // the base card has a single location, so its detail is always 1
    det_lo = (cf_kind_ff == `DCS_CF_BASE) ? 6'h01 : loc_ch; // [R10]
    if (attention_indicator && (diag_fault || validation_err)) begin
      c_hi[0] = `DCS_CH_S; c_lo[0] = `DCS_CH_E; // [R1]
      if (diag_fault) begin
        c_hi[1] = `DCS_CH_D; c_lo[1] = `DCS_CH_F; // [R19]
      end else begin
        c_hi[1] = `DCS_CH_S; c_lo[1] = val_ch; // [R7]
      end
      n_codes = 4'd2;
      err_pair = 1'b1;
    end else if (attention_indicator && (op_lockdown || diag_lockdown)) begin
      c_hi[0] = op_lockdown ? `DCS_CH_O : `DCS_CH_D; // [R8] [R9]
      c_lo[0] = `DCS_CH_E;
      c_hi[1] = `DCS_CH_L; c_lo[1] = lockdown_ch; // [R8]
      n_codes = 4'd2;
      err_pair = 1'b1;
    end else if (power_on_phase) begin
      c_hi[0] = `DCS_CH_S; c_lo[0] = `DCS_CH_E;
      c_hi[1] = `DCS_CH_8; c_lo[1] = `DCS_CH_8; // [R15]
      n_codes = 4'd2;
    end else if (cf_seen_ff) begin
      c_hi[0] = `DCS_CH_O; c_lo[0] = `DCS_CH_S; // [R14]
      c_hi[1] = `DCS_CH_C; c_lo[1] = `DCS_CH_F;
      c_hi[2] = det_hi;
      c_lo[2] = det_lo; // [R10]
      n_codes = 4'd3;
    end else if (offline_ff) begin
      c_hi[0] = `DCS_CH_O; c_lo[0] = `DCS_CH_S;
      c_hi[1] = `DCS_CH_O; c_lo[1] = `DCS_CH_L; // [R13]
      n_codes = 4'd2;
    end else if (over_temp) begin
      c_hi[0] = `DCS_CH_O; c_lo[0] = `DCS_CH_S;
      c_hi[1] = `DCS_CH_O; c_lo[1] = `DCS_CH_H; // [R18]
      n_codes = 4'd2;
    end else if (battery_backup) begin
      c_hi[0] = `DCS_CH_O; c_lo[0] = `DCS_CH_S;
      c_hi[1] = `DCS_CH_B; c_lo[1] = `DCS_CH_B; // [R17]
      n_codes = 4'd2;
    end else if (start_of_day) begin
      c_hi[0] = `DCS_CH_O; c_lo[0] = `DCS_CH_S;
      c_hi[1] = `DCS_CH_S; c_lo[1] = `DCS_CH_D; // [R16]
      n_codes = 4'd2;
    end else begin
      static_id = 1'b1; // [R12]
    end
    // a failure latched behind an error pair is a second pair, so the
    // separator goes between them; single-pair sequences never get one
    if (err_pair && cf_seen_ff) begin
      c_hi[2] = `DCS_CH_DASH; // [R5]
      c_lo[2] = `DCS_CH_DASH;
      c_hi[3] = `DCS_CH_C;
      c_lo[3] = `DCS_CH_F;
      c_hi[4] = det_hi;
      c_lo[4] = det_lo;
      n_codes = 4'd5;
    end
    c_hi[n_codes[2:0]] = `DCS_CH_BLANK; // [R6]
    c_lo[n_codes[2:0]] = `DCS_CH_BLANK;
  end

  // ------------------------------------------------------------
  // dwell timer and code index
  // ------------------------------------------------------------
  wire dwell_done = (dwell_ff >= DWELL_CYC - 1);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dwell_ff      <= 32'h0000_0000;
      idx_ff        <= 3'h0;
      showing_id_ff <= 1'b0;
    end else begin
      showing_id_ff <= static_id;
      if (static_id) begin
        dwell_ff <= 32'h0000_0000;
        idx_ff   <= 3'h0;
      end else if (dwell_done) begin
        dwell_ff <= 32'h0000_0000; // [R21]
        // wrap after the end glyph so the sequence repeats
        if ({1'b0, idx_ff} >= n_codes)
          idx_ff <= 3'h0; // [R6]
        else
          idx_ff <= idx_ff + 3'h1;
      end else begin
        dwell_ff <= dwell_ff + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // glyph output
  // ------------------------------------------------------------
  wire [`DCS_CH_W-1:0]  cur_hi = static_id ? encl_id_hi : c_hi[idx_ff];
  wire [`DCS_CH_W-1:0]  cur_lo = static_id ? encl_id_lo : c_lo[idx_ff];
  wire [`DCS_SEG_W-1:0] g_hi;
  wire [`DCS_SEG_W-1:0] g_lo;
  wire                  is_end = ({1'b0, idx_ff} >= n_codes);

  dcs_glyph u_hi (
    .ch   (cur_hi),
    .segs (g_hi)
  );
  dcs_glyph u_lo (
    .ch   (cur_lo),
    .segs (g_lo)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      seg_hi_ff   <= `DCS_SEG_OFF;
      seg_lo_ff   <= `DCS_SEG_OFF;
      diag_dot_ff <= 1'b0;
    end else begin
      seg_hi_ff   <= g_hi;
      seg_lo_ff   <= g_lo;
      // id and end glyph are minus codes, all others plus
      diag_dot_ff <= !(static_id || is_end); // [R2] [R4] [R12]
    end
  end
endmodule // dcs_sequencer
`default_nettype wire

// ==== tb/dcs_seq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcs_seq_properties #(
  parameter int DWELL_CYC = 4
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       attention_indicator,
  input wire logic       power_on_phase,
  input wire logic       start_of_day,
  input wire logic       battery_backup,
  input wire logic       over_temp,
  input wire logic       ctrl_reset_req,
  input wire logic       diag_fault,
  input wire logic       validation_err,
  input wire logic       op_lockdown,
  input wire logic       diag_lockdown,
  input wire logic [5:0] lockdown_ch,
  input wire logic       comp_fail,
  input wire logic       comp_clear,
  input wire logic [6:0] seg_hi_ff,
  input wire logic [6:0] seg_lo_ff,
  input wire logic       diag_dot_ff,
  input wire logic       ctrl_hold_ff
);
  wire  [17:0] ins = {attention_indicator, power_on_phase, start_of_day, battery_backup,
                      over_temp, ctrl_reset_req, diag_fault, validation_err, op_lockdown,
                      diag_lockdown, lockdown_ch, comp_fail, comp_clear};
  wire  [14:0] outs = {seg_hi_ff, seg_lo_ff, diag_dot_ff};
  wire         idle = comp_clear && !(|ins[17:12]) && !comp_fail;
  logic [31:0] quiet_ff;
  logic [31:0] run_ff;
  // -------------------------------------------------------------
  // input changes restart a code mid-dwell, so dwell is judged only when calm
  // -------------------------------------------------------------
  always @(posedge sys_clk) begin
    quiet_ff <= (!rst_n || ins != $past(ins)) ? 32'h0 : quiet_ff + 32'h1;
    run_ff   <= (!rst_n || outs != $past(outs)) ? 32'h0 : run_ff + 32'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_id_shown;
    (idle && $stable(ins)) [*4];
  endsequence
  sequence s_req_taken;
    $rose(ctrl_reset_req) ##1 ctrl_reset_req;
  endsequence
  sequence s_dash_left;
    $changed(outs) && $past(seg_hi_ff) == 7'h40 && quiet_ff > 2 * DWELL_CYC;
  endsequence
  AST_DASH_DOT: assert property (seg_hi_ff == 7'h40 && seg_lo_ff == 7'h40 |-> diag_dot_ff)
    else $error("separator shown with dot off");
  AST_DASH_NEXT: assert property (s_dash_left |-> {seg_hi_ff, seg_lo_ff} == 14'h1CF1)
    else $error("separator not followed by failure pair");
  AST_RST_CLEAR: assert property ($rose(rst_n) |-> outs == 15'h0000 && !ctrl_hold_ff)
    else $error("outputs not cleared by reset");
  AST_BLANK_DOT: assert property (seg_hi_ff == 7'h00 && seg_lo_ff == 7'h00 |-> !diag_dot_ff)
    else $error("dot lit on blank glyph");
  AST_DWELL: assert property ($changed(outs) && quiet_ff > 2 * DWELL_CYC |-> run_ff == DWELL_CYC - 1)
    else $error("code did not stand one dwell");
  AST_BLANK_AFTER: assert property ($fell(diag_dot_ff) && quiet_ff > 2 * DWELL_CYC |-> outs == 15'h0000)
    else $error("dot fell without end glyph");
  AST_END_REPEAT: assert property ($changed(outs) && $past(outs) == 15'h0000 && quiet_ff > 2 * DWELL_CYC |-> diag_dot_ff)
    else $error("sequence did not restart after end glyph");
  AST_ID_STATIC: assert property (s_id_shown |-> !diag_dot_ff && $stable(outs))
    else $error("enclosure id not static with dot off");
  AST_HOLD_SET: assert property (s_id_shown ##1 s_req_taken |-> ##1 ctrl_hold_ff)
    else $error("controller not held after reset request");
  AST_HOLD_DROP: assert property (!ctrl_reset_req |-> ##1 !ctrl_hold_ff)
    else $error("hold kept without reset request");
  AST_HOLD_REFUSE: assert property ($rose(ctrl_reset_req) && $past(power_on_phase) |-> ##1 !ctrl_hold_ff)
    else $error("hold taken while id not shown");
endmodule // dcs_seq_properties
bind dcs_sequencer dcs_seq_properties #(.DWELL_CYC(DWELL_CYC)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .attention_indicator(attention_indicator),
  .power_on_phase(power_on_phase), .start_of_day(start_of_day), .battery_backup(battery_backup),
  .over_temp(over_temp), .ctrl_reset_req(ctrl_reset_req), .diag_fault(diag_fault),
  .validation_err(validation_err), .op_lockdown(op_lockdown), .diag_lockdown(diag_lockdown),
  .lockdown_ch(lockdown_ch), .comp_fail(comp_fail), .comp_clear(comp_clear),
  .seg_hi_ff(seg_hi_ff), .seg_lo_ff(seg_lo_ff), .diag_dot_ff(diag_dot_ff),
  .ctrl_hold_ff(ctrl_hold_ff));
`default_nettype wire

// ==== tb/dcs_fw_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.vh"
module dcs_fw_model #(
  parameter [5:0] ID_HI = `DCS_CH_8,
  parameter [5:0] ID_LO = `DCS_CH_8
) (
  input  wire logic        sys_clk,
  input  wire logic [11:0] want,
  input  wire logic [5:0]  arg,
  output var  logic [11:0] flags_ff = 12'h001,
  output var  logic [5:0]  arg_ff = 6'h08,
  output wire logic [5:0]  id_hi,
  output wire logic [5:0]  id_lo
);
  // firmware settles its choice one clock after deciding, like a register write
  always @(posedge sys_clk) begin
    flags_ff <= want;
    arg_ff   <= arg;
  end
  assign id_hi = ID_HI;
  assign id_lo = ID_LO;
endmodule // dcs_fw_model
`default_nettype wire

// ==== tb/dcs_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.vh"
module dcs_sequencer_tb;
  localparam logic [11:0] F_CC = 12'h001, F_CF = 12'h002, F_DGL = 12'h004, F_OPL = 12'h008;
  localparam logic [11:0] F_VAL = 12'h010, F_DF = 12'h020, F_REQ = 12'h040, F_PWR = 12'h400;
  localparam logic [11:0] F_ATT = 12'h800;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [11:0] want    = F_CC;
  logic [5:0]  arg     = `DCS_CH_8;
  wire  [11:0] fq;
  wire  [5:0]  aq, ihi, ilo;
  wire  [6:0]  seg_hi, seg_lo;
  wire         dot, hold;
  int          err_count  = 0;
  int          n_compared = 0;
  logic        saw_blank, saw_code;
  logic [2:0]  kind       = `DCS_CF_HOST;
  // expected detail first characters for kinds d, C, P, H, F, b
  logic [6:0]  k_hi [6]   = '{7'h5E, 7'h39, 7'h73, 7'h76, 7'h71, 7'h7C};
  // rows: id power-on validation op lockdown diag lockdown
  // diag fault start-of-day battery over temperature
  logic [11:0] r_flg [9] = '{F_CC, F_PWR | F_CC, F_ATT | F_VAL | F_CC, F_ATT | F_OPL | F_CC,
                             F_ATT | F_DGL | F_CC, F_ATT | F_DF | F_CC, 12'h201, 12'h101, 12'h081};
  logic        r_lo  [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  always #5 sys_clk = ~sys_clk;
  dcs_fw_model u_fw (.sys_clk(sys_clk), .want(want), .arg(arg), .flags_ff(fq), .arg_ff(aq),
                     .id_hi(ihi), .id_lo(ilo));
  dcs_sequencer #(.DWELL_CYC(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .attention_indicator(fq[11]), .power_on_phase(fq[10]), .start_of_day(fq[9]),
    .battery_backup(fq[8]), .over_temp(fq[7]), .ctrl_reset_req(fq[6]), .diag_fault(fq[5]),
    .validation_err(fq[4]), .validation_idx(aq[3:0]), .op_lockdown(fq[3]),
    .diag_lockdown(fq[2]), .lockdown_ch(aq), .comp_fail(fq[1]), .comp_kind(kind),
    .comp_loc(aq[3:0]), .comp_clear(fq[0]), .encl_id_hi(ihi), .encl_id_lo(ilo),
    .seg_hi_ff(seg_hi), .seg_lo_ff(seg_lo), .diag_dot_ff(dot), .ctrl_hold_ff(hold));
  task automatic check(string what, logic [6:0] seen, logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one-edge reset so every case starts at code 0, then park on the last cycle of code 1
  task automatic start(logic [11:0] f, logic [5:0] a);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    want  <= f;
    arg   <= a;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  task automatic scan(int n);
    saw_blank = 1'b0;
    saw_code  = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (seg_hi === 7'h00 && seg_lo === 7'h00) saw_blank = 1'b1;
      if (seg_lo === 7'h7F && dot === 1'b1) saw_code = 1'b1;
    end
  endtask
  task automatic wait4();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    check("reset_hi", seg_hi, 7'h00);
    check("reset_flags", {5'h00, dot, hold}, 7'h00);
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      start(r_flg[i], `DCS_CH_8);
      check("code_dot", {6'h00, dot}, {6'h00, r_flg[i] != F_CC});
      if (r_lo[i]) check("code_lo", seg_lo, 7'h7F);
      wait4();
      check("end_hi", seg_hi, (r_flg[i] != F_CC) ? 7'h00 : 7'h7F);
      check("end_lo", seg_lo, (r_flg[i] != F_CC) ? 7'h00 : 7'h7F);
      check("end_dot", {6'h00, dot}, 7'h00);
      $display("row %0d done", i);
    end
    start(F_ATT | F_VAL | F_CC, 6'h05);
    check("s_glyph", seg_hi, 7'h6D);
    check("five_glyph", seg_lo, 7'h6D);
    $display("glyph test done");
    start(F_CC, `DCS_CH_8);
    @(posedge sys_clk) want <= F_CC | F_REQ;
    wait4();
    check("hold_on", {6'h00, hold}, 7'h01);
    check("offline_dot", {6'h00, dot}, 7'h01);
    @(posedge sys_clk) want <= F_CC;
    wait4();
    check("hold_off", {5'h00, hold, dot}, 7'h00);
    start(F_PWR | F_CC, `DCS_CH_8);
    @(posedge sys_clk) want <= F_PWR | F_CC | F_REQ;
    wait4();
    check("hold_refused", {6'h00, hold}, 7'h00);
    $display("offline test done");
    start(F_CC, `DCS_CH_8);
    @(posedge sys_clk) want <= F_CF;
    @(posedge sys_clk) want <= 12'h000;
    scan(20);
    check("fail_blank", {6'h00, saw_blank}, 7'h01);
    check("fail_host", {6'h00, saw_code}, 7'h01);
    @(posedge sys_clk) want <= F_REQ;
    scan(20);
    check("fail_kept", {6'h00, saw_blank}, 7'h01);
    check("fail_kept_code", {6'h00, saw_code}, 7'h01);
    @(posedge sys_clk) want <= F_CC;
    scan(6);
    check("id_back", {seg_lo[5:0], dot}, 7'h7E);
    $display("failure test done");
    // failure latched behind a startup error makes a second pair
    start(F_ATT | F_DF | F_CF, `DCS_CH_8);
    wait4();
    check("dash_hi", seg_hi, 7'h40);
    check("dash_lo", seg_lo, 7'h40);
    check("dash_dot", {6'h00, dot}, 7'h01);
    wait4();
    check("pair2_hi", seg_hi, 7'h39);
    check("pair2_lo", seg_lo, 7'h71);
    wait4();
    check("pair2_det", seg_hi, 7'h76);
    wait4();
    check("pair2_end", {seg_hi[5:0], dot}, 7'h00);
    $display("separator test done");
    for (int i = 0; i < 6; i++) begin
      start(F_CC, `DCS_CH_8);
      @(posedge sys_clk) begin
        want <= F_CF;
        kind <= i[2:0];
      end
      @(posedge sys_clk) want <= 12'h000;
      repeat (11) @(posedge sys_clk);
      #1;
      check("kind_hi", seg_hi, k_hi[i]);
      check("kind_lo", seg_lo, (i == 5) ? 7'h06 : 7'h7F);
    end
    $display("component kind test done");
    conclude();
  end
  // the whole run is a few hundred cycles; this allows far more
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule // dcs_sequencer_tb
`default_nettype wire
